//--- include/blcs_pkg.sv
// Shared constants, types and decode functions for the contact stack unit
package blcs_pkg;

  // Logic stack: top level plus eight below it; a push loses the deepest
  localparam int STACK_DEPTH = 9;

  // Edge instances, each with its own remembered input bit
  localparam int EDGE_COUNT  = 256;
  localparam int EDGE_IDX_W  = 8;

  // Physical input points reachable by the direct contacts
  localparam int PHYS_POINTS = 16;
  localparam int PHYS_SEL_W  = 4;

  // Graphical AND/OR box expansion
  localparam int BOX_MAX_INPUTS = 32;
  localparam int BOX_CNT_W      = 6;
  localparam logic [BOX_CNT_W-1:0] BOX_MIN_COUNT = 6'h01;
  localparam logic [BOX_CNT_W-1:0] BOX_MAX_COUNT = 6'h20;

  // Double-word image access: highest legal starting byte
  localparam int DWORD_BYTE_W = 8;
  localparam logic [DWORD_BYTE_W-1:0] DWORD_IMAGE_LAST_BYTE = 8'h0c;

  // Reset value of every stack level and edge memory bit
  localparam logic BIT_RESET = 1'b0;

  // Instruction codes
  typedef enum logic [3:0] {
    op_load_open_contact   = 4'h0,
    op_load_closed_contact = 4'h1,
    op_and_open_contact    = 4'h2,
    op_and_closed_contact  = 4'h3,
    op_or_open_contact     = 4'h4,
    op_or_closed_contact   = 4'h5,
    op_load_open_direct    = 4'h6,
    op_and_open_direct     = 4'h7,
    op_or_open_direct      = 4'h8,
    op_load_closed_direct  = 4'h9,
    op_and_closed_direct   = 4'ha,
    op_or_closed_direct    = 4'hb,
    op_not_top             = 4'hc,
    op_rising_edge_pulse   = 4'hd,
    op_falling_edge_pulse  = 4'he,
    op_box_logic           = 4'hf
  } blcs_op_type;

  // How a contact value meets the stack
  typedef enum logic [1:0] {
    comb_load = 2'b00,
    comb_and  = 2'b01,
    comb_or   = 2'b10,
    comb_none = 2'b11
  } blcs_comb_type;

  // Combining mode of a contact instruction
  function automatic blcs_comb_type op_comb(input blcs_op_type op);
    unique case (op)
      op_load_open_contact, op_load_closed_contact,
      op_load_open_direct, op_load_closed_direct:   op_comb = comb_load;
      op_and_open_contact, op_and_closed_contact,
      op_and_open_direct, op_and_closed_direct:     op_comb = comb_and;
      op_or_open_contact, op_or_closed_contact,
      op_or_open_direct, op_or_closed_direct:       op_comb = comb_or;
      op_not_top, op_rising_edge_pulse,
      op_falling_edge_pulse, op_box_logic:          op_comb = comb_none;
    endcase
  endfunction : op_comb

  // Closed-type contacts use the inverted operand
  function automatic logic op_closed(input blcs_op_type op);
    op_closed = (op == op_load_closed_contact) ||
                (op == op_and_closed_contact)  ||
                (op == op_or_closed_contact)   ||
                (op == op_load_closed_direct)  ||
                (op == op_and_closed_direct)   ||
                (op == op_or_closed_direct);
  endfunction : op_closed

  // Direct contacts read the physical point, not the image
  function automatic logic op_direct(input blcs_op_type op);
    op_direct = (op == op_load_open_direct)   ||
                (op == op_and_open_direct)    ||
                (op == op_or_open_direct)     ||
                (op == op_load_closed_direct) ||
                (op == op_and_closed_direct)  ||
                (op == op_or_closed_direct);
  endfunction : op_direct

endpackage : blcs_pkg

//--- logic/blcs_box_reduce.sv
// Combinational AND/OR reduction for an expanded graphical box
`timescale 1ns/1ns
module blcs_box_reduce
(
  input  wire logic [blcs_pkg::BOX_MAX_INPUTS-1:0] bits_i,
  input  wire logic [blcs_pkg::BOX_CNT_W-1:0]      count_i,
  input  wire logic                                or_mode_i,
  output logic                                     result_o,
  output logic                                     count_ok_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Only the first count_i inputs take part; unused ones are neutral
  always_comb
  begin
    logic acc_and;
    logic acc_or;
    acc_and = 1'b1;
    acc_or  = 1'b0;
    for (int i = 0; i < blcs_pkg::BOX_MAX_INPUTS; i++)
    begin
      if (blcs_pkg::BOX_CNT_W'(i) < count_i)
      begin
        acc_and = acc_and & bits_i[i];
        acc_or  = acc_or | bits_i[i];
      end
    end
    result_o = or_mode_i ? acc_or : acc_and;
  end

  // Up to thirty-two inputs; zero inputs is not a box
  assign count_ok_o = (count_i >= blcs_pkg::BOX_MIN_COUNT) &&
                      (count_i <= blcs_pkg::BOX_MAX_COUNT);

endmodule : blcs_box_reduce

//--- logic/blcs_contact_unit.sv
// Bit-logic contact execution unit with logic stack and edge memory
`timescale 1ns/1ns

module blcs_contact_unit
(
  input  wire logic                                 clk_i,
  input  wire logic                                 nrst_i,
  input  wire logic                                 op_valid_i,
  input  wire blcs_pkg::blcs_op_type                op_i,
  input  wire logic                                 operand_bit_i,
  input  wire logic [blcs_pkg::PHYS_SEL_W-1:0]      phys_sel_i,
  input  wire logic [blcs_pkg::PHYS_POINTS-1:0]     phys_pins_i,
  input  wire logic [blcs_pkg::EDGE_IDX_W-1:0]      edge_idx_i,
  input  wire logic                                 first_scan_i,
  input  wire logic [blcs_pkg::BOX_MAX_INPUTS-1:0]  box_bits_i,
  input  wire logic [blcs_pkg::BOX_CNT_W-1:0]       box_count_i,
  input  wire logic                                 box_or_i,
  input  wire logic                                 dword_req_i,
  input  wire logic [blcs_pkg::DWORD_BYTE_W-1:0]    dword_byte_i,
  output logic                                      tos_o,
  output logic      [blcs_pkg::STACK_DEPTH-1:0]     stack_o,
  output logic                                      done_o,
  output logic                                      error_o,
  output logic                                      dword_done_o,
  output logic                                      dword_ok_o
);

  localparam int SD = blcs_pkg::STACK_DEPTH;

  typedef struct packed {
    logic [SD-1:0]                   stack;
    logic [blcs_pkg::EDGE_COUNT-1:0] edge_prev;
    logic                            done;
    logic                            error;
    logic                            dword_done;
    logic                            dword_ok;
  } blcs_state_type;

  blcs_state_type s_q;
  blcs_state_type s_d;

  logic [blcs_pkg::PHYS_POINTS-1:0] phys_sync;
  logic                             box_val;
  logic                             box_count_ok;
  logic                             direct_bit;
  logic                             prev_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Pins come from outside the clock domain, so they are synchronised
  blcs_input_sync u_sync
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .pins_i (phys_pins_i),
    .sync_o (phys_sync)
  );

  // Expanded AND/OR box
  blcs_box_reduce u_box
  (
    .bits_i     (box_bits_i),
    .count_i    (box_count_i),
    .or_mode_i  (box_or_i),
    .result_o   (box_val),
    .count_ok_o (box_count_ok)
  );

  // Current physical point and the selected edge instance's memory
  assign direct_bit = phys_sync[phys_sel_i];
  assign prev_bit   = s_q.edge_prev[edge_idx_i];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction execution: one instruction per cycle, result next edge
  always_comb
  begin
    logic operand;
    logic contact;
    logic pulse;
    operand = 1'b0;
    contact = 1'b0;
    pulse   = 1'b0;
    s_d            = s_q;
    s_d.done       = 1'b0;
    s_d.error      = 1'b0;
    s_d.dword_done = 1'b0;

    // Direct forms bypass the image; the image itself is never written
    operand = blcs_pkg::op_direct(op_i) ? direct_bit
                                        : operand_bit_i;
    contact = blcs_pkg::op_closed(op_i) ? ~operand : operand;

    if (op_valid_i)
    begin
      s_d.done = 1'b1;
      unique case (op_i)
        blcs_pkg::op_not_top:
        begin
          s_d.stack[0] = ~s_q.stack[0];
        end
        blcs_pkg::op_rising_edge_pulse,
        blcs_pkg::op_falling_edge_pulse:
        begin
          if (op_i == blcs_pkg::op_rising_edge_pulse)
          begin
            pulse = s_q.stack[0] & ~prev_bit;
          end
          else
          begin
            pulse = ~s_q.stack[0] & prev_bit;
          end
          // No history exists yet on the first scan
          s_d.stack[0] = first_scan_i ? 1'b0 : pulse;
          s_d.edge_prev[edge_idx_i] = s_q.stack[0];
        end
        blcs_pkg::op_box_logic:
        begin
          if (box_count_ok)
          begin
            s_d.stack = {s_q.stack[SD-2:0], box_val};
          end
          else
          begin
            // Bad width: stack left alone so the rung is not corrupted
            s_d.error = 1'b1;
            s_d.done  = 1'b0;
          end
        end
        blcs_pkg::op_load_open_contact, blcs_pkg::op_load_closed_contact,
        blcs_pkg::op_and_open_contact, blcs_pkg::op_and_closed_contact,
        blcs_pkg::op_or_open_contact, blcs_pkg::op_or_closed_contact,
        blcs_pkg::op_load_open_direct, blcs_pkg::op_and_open_direct,
        blcs_pkg::op_or_open_direct, blcs_pkg::op_load_closed_direct,
        blcs_pkg::op_and_closed_direct, blcs_pkg::op_or_closed_direct:
        begin
          unique case (blcs_pkg::op_comb(op_i))
            blcs_pkg::comb_load:
            begin
              s_d.stack = {s_q.stack[SD-2:0], contact};
            end
            blcs_pkg::comb_and:
            begin
              s_d.stack[0] = s_q.stack[0] & contact;
            end
            blcs_pkg::comb_or:
            begin
              s_d.stack[0] = s_q.stack[0] | contact;
            end
            blcs_pkg::comb_none:
            begin
              s_d.stack = s_q.stack;
            end
          endcase
        end
      endcase
    end

    // Double-word image address check, independent of the stack
    if (dword_req_i)
    begin
      s_d.dword_done = 1'b1;
      s_d.dword_ok   = (dword_byte_i <=
                        blcs_pkg::DWORD_IMAGE_LAST_BYTE);
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign tos_o        = s_q.stack[0];
  assign stack_o      = s_q.stack;
  assign done_o       = s_q.done;
  assign error_o      = s_q.error;
  assign dword_done_o = s_q.dword_done;
  assign dword_ok_o   = s_q.dword_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_load_open;
    op_valid_i && op_i == blcs_pkg::op_load_open_contact
      |=> tos_o == $past(operand_bit_i);
  endproperty
  a_load_open: assert property (p_load_open)
    else $error("open contact load wrong value");

  property p_load_closed;
    op_valid_i && op_i == blcs_pkg::op_load_closed_contact
      |=> tos_o == !$past(operand_bit_i);
  endproperty
  a_load_closed: assert property (p_load_closed)
    else $error("closed contact load wrong value");

  property p_and_closed;
    op_valid_i && op_i == blcs_pkg::op_and_closed_contact
      |=> tos_o == ($past(tos_o) & !$past(operand_bit_i))
          && stack_o[SD-1:1] == $past(stack_o[SD-1:1]);
  endproperty
  a_and_closed: assert property (p_and_closed)
    else $error("closed contact and wrong value");

  property p_or_open;
    op_valid_i && op_i == blcs_pkg::op_or_open_contact
      |=> tos_o == ($past(tos_o) | $past(operand_bit_i));
  endproperty
  a_or_open: assert property (p_or_open)
    else $error("open contact or wrong value");

  property p_direct_open;
    op_valid_i && op_i == blcs_pkg::op_load_open_direct
      |=> tos_o == $past(direct_bit);
  endproperty
  a_direct_open: assert property (p_direct_open)
    else $error("direct open load did not use pin");

  property p_direct_closed;
    op_valid_i && op_i == blcs_pkg::op_and_closed_direct
      |=> tos_o == ($past(tos_o) & !$past(direct_bit));
  endproperty
  a_direct_closed: assert property (p_direct_closed)
    else $error("direct closed and wrong value");

  property p_not;
    op_valid_i && op_i == blcs_pkg::op_not_top
      |=> tos_o != $past(tos_o) && stack_o[SD-1:1] == $past(stack_o[SD-1:1]);
  endproperty
  a_not: assert property (p_not)
    else $error("not did not complement top only");

  property p_rise;
    op_valid_i && op_i == blcs_pkg::op_rising_edge_pulse && !first_scan_i
      |=> tos_o == ($past(tos_o) & !$past(prev_bit));
  endproperty
  a_rise: assert property (p_rise)
    else $error("rising edge result wrong");

  property p_fall;
    op_valid_i && op_i == blcs_pkg::op_falling_edge_pulse && !first_scan_i
      |=> tos_o == (!$past(tos_o) & $past(prev_bit));
  endproperty
  a_fall: assert property (p_fall)
    else $error("falling edge result wrong");

  property p_first_scan;
    op_valid_i && first_scan_i && (op_i == blcs_pkg::op_rising_edge_pulse ||
      op_i == blcs_pkg::op_falling_edge_pulse) |=> !tos_o;
  endproperty
  a_first_scan: assert property (p_first_scan)
    else $error("edge reported on first scan");

  // Every level moves down one; the deepest old level falls off
  property p_push;
    op_valid_i && blcs_pkg::op_comb(op_i) == blcs_pkg::comb_load
      |=> stack_o[SD-1:1] == $past(stack_o[SD-2:0]) && done_o;
  endproperty
  a_push: assert property (p_push)
    else $error("load did not push the stack");

  property p_box_refuse;
    op_valid_i && op_i == blcs_pkg::op_box_logic &&
      box_count_i > blcs_pkg::BOX_MAX_COUNT
      |=> error_o && !done_o && stack_o == $past(stack_o);
  endproperty
  a_box_refuse: assert property (p_box_refuse)
    else $error("oversized box not refused");

  property p_dword;
    dword_req_i |=> dword_done_o &&
      dword_ok_o == ($past(dword_byte_i) <= blcs_pkg::DWORD_IMAGE_LAST_BYTE);
  endproperty
  a_dword: assert property (p_dword)
    else $error("double word range answer wrong");

  // Both edge kinds record the top, first scan included
  property p_edge_mem;
    op_valid_i && (op_i == blcs_pkg::op_rising_edge_pulse ||
      op_i == blcs_pkg::op_falling_edge_pulse)
      |=> s_q.edge_prev[$past(edge_idx_i)] == $past(tos_o);
  endproperty
  a_edge_mem: assert property (p_edge_mem)
    else $error("edge memory not updated");

  c_rise_pulse: cover property (op_valid_i && !first_scan_i &&
    op_i == blcs_pkg::op_rising_edge_pulse ##1 tos_o);
  c_box_full: cover property (op_valid_i &&
    op_i == blcs_pkg::op_box_logic && box_count_i == blcs_pkg::BOX_MAX_COUNT);
  c_direct: cover property (op_valid_i &&
    op_i == blcs_pkg::op_or_closed_direct);
  c_dword_bad: cover property (dword_done_o && !dword_ok_o);

endmodule : blcs_contact_unit

//--- logic/blcs_input_sync.sv
// Two-stage synchroniser for the physical input points
`timescale 1ns/1ns
module blcs_input_sync
(
  input  wire logic                               clk_i,
  input  wire logic                               nrst_i,
  input  wire logic [blcs_pkg::PHYS_POINTS-1:0]   pins_i,
  output logic      [blcs_pkg::PHYS_POINTS-1:0]   sync_o
);

  typedef struct packed {
    logic [blcs_pkg::PHYS_POINTS-1:0] meta;
    logic [blcs_pkg::PHYS_POINTS-1:0] sync;
  } blcs_sync_state_type;

  blcs_sync_state_type s_q;
  blcs_sync_state_type s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: the first stage feeds only the second stage
  always_comb
  begin
    s_d      = s_q;
    s_d.meta = pins_i;
    s_d.sync = s_q.meta;
  end

  // Register; reset to a constant, never to a pin level
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.sync;

endmodule : blcs_input_sync

//--- verification/blcs_contact_unit_tb.sv
// Self-checking bench for the contact stack unit
`timescale 1ns/1ns
module blcs_contact_unit_tb;
  logic clk_i = 1'b0, nrst_i = 1'b0, op_valid_i = 1'b0, first_scan_i = 1'b0;
  logic box_or_i = 1'b0, dword_req_i = 1'b0, load_pins = 1'b0;
  blcs_pkg::blcs_op_type op_i = blcs_pkg::op_not_top;
  logic [3:0]  phys_sel_i = 4'h0;
  logic [7:0]  edge_idx_i = 8'h00, dword_byte_i = 8'h00;
  logic [31:0] box_bits_i = 32'h0;
  logic [5:0]  box_count_i = 6'h01, img_addr = 6'h00;
  logic [15:0] new_pins = 16'h0, pins_q = 16'h0;
  logic [15:0] phys_pins_i;
  logic operand_bit_i, tos_o, done_o, error_o, dword_done_o, dword_ok_o;
  logic [8:0]  stack_o, st = 9'h0;
  logic [255:0] emem = '0;
  logic [9:0] exp_q[$];
  logic       dw_q[$];
  int n_errors = 0, num_checks = 0;

  always #5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  blcs_image_model blcs_image_model_inst (.clk_i(clk_i), .addr_i(img_addr),
    .load_pins_i(load_pins), .new_pins_i(new_pins),
    .operand_bit_o(operand_bit_i), .pins_o(phys_pins_i));

  blcs_contact_unit blcs_contact_unit_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .operand_bit_i(operand_bit_i),
    .phys_sel_i(phys_sel_i), .phys_pins_i(phys_pins_i),
    .edge_idx_i(edge_idx_i), .first_scan_i(first_scan_i),
    .box_bits_i(box_bits_i), .box_count_i(box_count_i), .box_or_i(box_or_i),
    .dword_req_i(dword_req_i), .dword_byte_i(dword_byte_i), .tos_o(tos_o),
    .stack_o(stack_o), .done_o(done_o), .error_o(error_o),
    .dword_done_o(dword_done_o), .dword_ok_o(dword_ok_o));

  ////////////////////////////////////////////////////////////////////////////
  // One comparison, counted; a mismatch is reported at once
  task automatic chk(input string name, input logic [8:0] e,
                     input logic [8:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // Issue one instruction at a falling edge and note what must come back;
  // the reference stack is worked out here, not read from the design
  task automatic exec(input logic [3:0] code, input logic [5:0] cnt);
    logic v, t, prv, r, err;
    logic [3:0] k;
    logic [1:0] mode;
    logic [63:0] mask;
    @(negedge clk_i);
    op_valid_i   = 1'b1;
    op_i         = blcs_pkg::blcs_op_type'(code);
    img_addr     = 6'($urandom);
    phys_sel_i   = 4'($urandom);
    edge_idx_i   = 8'($urandom_range(0, 3));
    box_bits_i   = $urandom;
    box_or_i     = 1'($urandom);
    box_count_i  = cnt;
    dword_req_i  = 1'($urandom);
    dword_byte_i = ($urandom_range(0, 7) == 0) ? 8'hff :
                   8'($urandom_range(0, 15));
    if (dword_req_i)
      dw_q.push_back(dword_byte_i <= 8'h0c);
    #1;
    err = 1'b0;
    if (code <= 4'h5)
    begin
      v    = operand_bit_i ^ code[0];
      mode = code[2:1];
    end
    else if (code <= 4'hb)
    begin
      k    = code - 4'h6;
      v    = pins_q[phys_sel_i] ^ (k >= 4'h3);
      mode = 2'(k % 4'h3);
    end
    else
      mode = 2'h3;
    if (mode == 2'h0)
      st = {st[7:0], v};
    else if (mode == 2'h1)
      st[0] = st[0] & v;
    else if (mode == 2'h2)
      st[0] = st[0] | v;
    else if (code == 4'hc)
      st[0] = ~st[0];
    else if (code == 4'hd || code == 4'he)
    begin
      t   = st[0];
      prv = emem[edge_idx_i];
      st[0] = first_scan_i ? 1'b0 :
              (code == 4'hd) ? (t & ~prv) : (~t & prv);
      emem[edge_idx_i] = t;
    end
    else
    begin
      err  = (cnt == 6'h00) || (cnt > 6'h20);
      mask = (64'h1 << cnt) - 64'h1;
      r = box_or_i ? |({32'h0, box_bits_i} & mask) :
                     &({32'h0, box_bits_i} | ~mask);
      if (!err)
        st = {st[7:0], r};
    end
    exp_q.push_back({err, st});
  endtask : exec

  task automatic idle(input int n);
    @(negedge clk_i);
    op_valid_i  = 1'b0;
    dword_req_i = 1'b0;
    repeat (n) @(negedge clk_i);
  endtask : idle

  ////////////////////////////////////////////////////////////////////////////
  // Watch the outputs at the falling edge, where they have settled
  always @(negedge clk_i)
  begin
    logic [9:0] e;
    if (nrst_i && (done_o === 1'b1 || error_o === 1'b1))
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3ff;
      chk("stack_o", e[8:0], stack_o);
      chk("tos_o", {8'h0, e[0]}, {8'h0, tos_o});
      chk("error_o", {8'h0, e[9]}, {8'h0, error_o});
      chk("done_o", {8'h0, ~e[9]}, {8'h0, done_o});
    end
    if (nrst_i && dword_done_o === 1'b1)
      chk("dword_ok_o", {8'h0, dw_q.size() > 0 ? dw_q.pop_front() : 1'bx},
          {8'h0, dword_ok_o});
  end

  // Cut a hang short well past the expected run length
  initial
  begin
    #400000;
    n_errors++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [5:0] cnts[5];
    cnts = '{6'h00, 6'h01, 6'h20, 6'h21, 6'h3f};
    void'($urandom(32'hfc52));
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    // First scan: edge ops record the top and clear it, no pulse
    first_scan_i = 1'b1;
    for (int i = 0; i < 8; i++)
      exec((i % 2) ? 4'hd : 4'he, 6'h01);
    idle(1);
    first_scan_i = 1'b0;
    for (int p = 0; p < 12; p++)
    begin
      // Pins settle through the two-flop synchroniser before use
      @(negedge clk_i);
      new_pins  = 16'($urandom);
      load_pins = 1'b1;
      @(negedge clk_i);
      load_pins = 1'b0;
      pins_q    = new_pins;
      repeat (3) @(negedge clk_i);
      for (int c = 0; c < 16; c++)
        exec(4'(c), 6'($urandom_range(1, 32)));
      for (int i = 0; i < 60; i++)
        exec(4'($urandom_range(0, 15)),
             cnts[$urandom_range(0, 4)]);
      idle(2);
    end
    // Second reset in mid-run clears stack and edge memories
    @(negedge clk_i);
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("stack_o reset", 9'h000, stack_o);
    nrst_i = 1'b1;
    st   = 9'h0;
    emem = '0;
    exec(4'h0, 6'h01);
    for (int i = 0; i < 8; i++)
      exec(4'hd + 4'(i % 2), 6'h01);
    idle(3);
    chk("pending", 9'h000, 9'(exp_q.size() + dw_q.size()));
    report_and_stop();
  end
endmodule : blcs_contact_unit_tb

//--- verification/blcs_image_model.sv
// Behavioural model of the physical input points and the image memory
`timescale 1ns/1ns
module blcs_image_model
#(
  parameter logic [63:0] IMAGE_INIT = 64'h3c5a_96f0_0ff1_a5c3
)
(
  input  wire logic        clk_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic        load_pins_i,
  input  wire logic [15:0] new_pins_i,
  output logic             operand_bit_o,
  output logic      [15:0] pins_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Standard contacts see the image copy, never the pins
  assign operand_bit_o = IMAGE_INIT[addr_i];

  ////////////////////////////////////////////////////////////////////////////
  // Pins move only on request; a direct read never writes the image
  initial pins_o = 16'h0000;
  always @(posedge clk_i)
  begin
    if (load_pins_i)
      pins_o <= new_pins_i;
  end
endmodule : blcs_image_model
